// *** pkg/tcr_pkg.sv ***
// package: register map, field layout and state record of the 16-bit timer unit
package tcr_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [9:0] IDX_CTRL_A = 10'h090;
    localparam logic [9:0] IDX_CTRL_B = 10'h091;
    localparam logic [9:0] IDX_FORCE = 10'h092;
    localparam logic [9:0] IDX_FLAGS = 10'h093;
    localparam logic [9:0] IDX_CNT_LO = 10'h094;
    localparam logic [9:0] IDX_CNT_HI = 10'h095;
    localparam logic [9:0] IDX_CAP_LO = 10'h096;
    localparam logic [9:0] IDX_CAP_HI = 10'h097;
    localparam logic [9:0] IDX_CMPA_LO = 10'h098;
    localparam logic [9:0] IDX_CMPA_HI = 10'h099;
    localparam logic [9:0] IDX_CMPB_LO = 10'h09A;
    localparam logic [9:0] IDX_CMPB_HI = 10'h09B;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CA_ACT_A_LSB = 6;
    localparam int CA_ACT_B_LSB = 4;
    localparam int CA_WAVE_LSB = 0;
    localparam int CB_NOISE_BIT = 7;
    localparam int CB_EDGE_BIT = 6;
    localparam int CB_SRC_BIT = 5;
    localparam int CB_WAVE_LSB = 3;
    localparam int CB_CS_LSB = 0;
    localparam int FC_A_BIT = 7;
    localparam int FC_B_BIT = 6;
    localparam int FL_CAP_BIT = 5;
    localparam int FL_CMPB_BIT = 2;
    localparam int FL_CMPA_BIT = 1;
    localparam int FL_OVF_BIT = 0;

    // ****************************************************************
    // reset values and constants
    // ****************************************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [15:0] MAX_COUNT = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam int PRESC_WIDTH = 10;
    localparam logic [9:0] TAP_DIV8 = 10'h007;
    localparam logic [9:0] TAP_DIV64 = 10'h03F;
    localparam logic [9:0] TAP_DIV256 = 10'h0FF;
    localparam logic [9:0] TAP_DIV1024 = 10'h3FF;
    localparam int NOISE_SAMPLES = 4;

    // ****************************************************************
    // enumerations
    // ****************************************************************
    typedef enum logic [2:0] {
        TCR_CS_STOP = 3'b000,
        TCR_CS_DIV1 = 3'b001,
        TCR_CS_DIV8 = 3'b010,
        TCR_CS_DIV64 = 3'b011,
        TCR_CS_DIV256 = 3'b100,
        TCR_CS_DIV1024 = 3'b101,
        TCR_CS_EXT_FALL = 3'b110,
        TCR_CS_EXT_RISE = 3'b111
    } tcr_clk_sel_t;

    typedef enum logic [1:0] {
        TCR_KIND_NONPWM = 2'b00,
        TCR_KIND_FAST = 2'b01,
        TCR_KIND_PHASE = 2'b10
    } tcr_kind_t;

    // ****************************************************************
    // whole state of the unit
    // ****************************************************************
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capture;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [7:0] temp;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] flags;
        logic [PRESC_WIDTH-1:0] presc;
        logic ext_prev;
        logic [NOISE_SAMPLES-1:0] cap_hist;
        logic cap_filt;
        logic count_down;
        logic block_match;
        logic wave_a;
        logic wave_b;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tcr_state_t;

endpackage : tcr_pkg

// *** design/tcr_timer16.sv ***
// design: 16-bit timer/counter with capture, two compare channels and APB registers
`timescale 1ns/1ps

module tcr_timer16 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_input_pin,
    input wire logic analog_cmp_in,
    input wire logic external_count_pin,
    output logic wave_out_chan_a,
    output logic wave_out_chan_b
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic tcr_pkg::tcr_kind_t mode_kind(input logic [3:0] wgm);
        tcr_pkg::tcr_kind_t k;
        k = tcr_pkg::TCR_KIND_NONPWM;
        case (wgm)
            4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11: k = tcr_pkg::TCR_KIND_PHASE;
            4'd5, 4'd6, 4'd7, 4'd14, 4'd15: k = tcr_pkg::TCR_KIND_FAST;
            default: k = tcr_pkg::TCR_KIND_NONPWM;
        endcase
        return k;
    endfunction : mode_kind

    function automatic logic [15:0] mode_top(input logic [3:0] wgm, input logic [15:0] cap,
                                            input logic [15:0] cmpa);
        logic [15:0] t;
        t = tcr_pkg::MAX_COUNT;
        case (wgm)
            4'd1, 4'd5: t = tcr_pkg::TOP_8BIT;
            4'd2, 4'd6: t = tcr_pkg::TOP_9BIT;
            4'd3, 4'd7: t = tcr_pkg::TOP_10BIT;
            4'd4, 4'd9, 4'd11, 4'd15: t = cmpa;
            4'd8, 4'd10, 4'd12, 4'd14: t = cap;
            default: t = tcr_pkg::MAX_COUNT;
        endcase
        return t;
    endfunction : mode_top

    // non-PWM action: 01 toggle, 10 clear, 11 set
    function automatic logic act_match(input logic cur, input logic [1:0] act);
        logic v;
        v = cur;
        case (act)
            2'b01: v = ~cur;
            2'b10: v = 1'b0;
            2'b11: v = 1'b1;
            default: v = cur;
        endcase
        return v;
    endfunction : act_match

    // PWM action: 10 clears on the primary event, sets on the secondary; 11 inverted
    function automatic logic act_pwm(input logic cur, input logic [1:0] act,
                                     input logic prim, input logic sec);
        logic v;
        v = cur;
        if (act[1])
        begin
            if (prim)
                v = act[0];
            else if (sec)
                v = ~act[0];
        end
        return v;
    endfunction : act_pwm

    // ****************************************************************
    // state
    // ****************************************************************
    tcr_pkg::tcr_state_t s;
    tcr_pkg::tcr_state_t next_s;

    logic [3:0] wgm;
    tcr_pkg::tcr_kind_t kind;
    logic [15:0] top;
    logic cap_is_top;
    logic tick;
    logic [9:0] idx;
    logic addr_ok;
    logic setup_ph;
    logic wr_done;
    logic [7:0] rd_byte;
    logic map_hit;
    logic match_a;
    logic match_b;
    logic at_top;
    logic at_bottom;
    logic ovf;
    logic cap_raw;
    logic cap_edge;
    logic next_filt;
    logic [1:0] act_a;
    logic [1:0] act_b;

    assign wgm = {s.ctrl_b[tcr_pkg::CB_WAVE_LSB +: 2], s.ctrl_a[tcr_pkg::CA_WAVE_LSB +: 2]};
    assign kind = mode_kind(wgm);
    assign top = mode_top(wgm, s.capture, s.cmp_a);
    assign cap_is_top = (wgm == 4'd8) || (wgm == 4'd10) || (wgm == 4'd12) || (wgm == 4'd14);
    assign act_a = s.ctrl_a[tcr_pkg::CA_ACT_A_LSB +: 2];
    assign act_b = s.ctrl_a[tcr_pkg::CA_ACT_B_LSB +: 2];

    // ****************************************************************
    // timer clock select
    // ****************************************************************
    // prescaler runs free so switching taps never restarts it
    always_comb
    begin
        case (tcr_pkg::tcr_clk_sel_t'(s.ctrl_b[tcr_pkg::CB_CS_LSB +: 3]))
            tcr_pkg::TCR_CS_STOP: tick = 1'b0;
            tcr_pkg::TCR_CS_DIV1: tick = 1'b1;
            tcr_pkg::TCR_CS_DIV8:
                tick = (s.presc & tcr_pkg::TAP_DIV8) == tcr_pkg::TAP_DIV8;
            tcr_pkg::TCR_CS_DIV64:
                tick = (s.presc & tcr_pkg::TAP_DIV64) == tcr_pkg::TAP_DIV64;
            tcr_pkg::TCR_CS_DIV256:
                tick = (s.presc & tcr_pkg::TAP_DIV256) == tcr_pkg::TAP_DIV256;
            tcr_pkg::TCR_CS_DIV1024:
                tick = (s.presc & tcr_pkg::TAP_DIV1024) == tcr_pkg::TAP_DIV1024;
            tcr_pkg::TCR_CS_EXT_FALL: tick = s.ext_prev & ~external_count_pin;
            tcr_pkg::TCR_CS_EXT_RISE: tick = ~s.ext_prev & external_count_pin;
            default: tick = 1'b0;
        endcase
    end

    // ****************************************************************
    // counter events
    // ****************************************************************
    assign at_top = (s.count == top);
    assign at_bottom = (s.count == 16'h0000);
    // a counter write blanks the compare units for one tick
    assign match_a = tick && !s.block_match && (s.count == s.cmp_a);
    assign match_b = tick && !s.block_match && (s.count == s.cmp_b);

    always_comb
    begin
        case (kind)
            tcr_pkg::TCR_KIND_FAST: ovf = tick && at_top;
            tcr_pkg::TCR_KIND_PHASE: ovf = tick && s.count_down && at_bottom;
            default: ovf = tick && (s.count == tcr_pkg::MAX_COUNT);
        endcase
    end

    // ****************************************************************
    // capture input
    // ****************************************************************
    assign cap_raw = s.ctrl_b[tcr_pkg::CB_SRC_BIT] ? analog_cmp_in : capture_input_pin;
    // filter kept apart from the state update so the edge test forms no loop
    always_comb
    begin
        next_filt = s.cap_filt;
        if (!s.ctrl_b[tcr_pkg::CB_NOISE_BIT])
            next_filt = cap_raw;
        else if (&s.cap_hist)
            next_filt = 1'b1;
        else if (~|s.cap_hist)
            next_filt = 1'b0;
    end

    assign cap_edge = (s.ctrl_b[tcr_pkg::CB_EDGE_BIT] ? (!s.cap_filt && next_filt)
                                                      : (s.cap_filt && !next_filt));

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign idx = paddr[11:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (idx >= tcr_pkg::IDX_CTRL_A)
                     && (idx <= tcr_pkg::IDX_CMPB_HI);
    assign setup_ph = psel && !penable;
    // writes land only at the edge where pready is seen high
    assign wr_done = psel && penable && s.pready && pwrite && !s.pslverr;

    always_comb
    begin
        rd_byte = 8'h00;
        map_hit = 1'b1;
        case (idx)
            tcr_pkg::IDX_CTRL_A: rd_byte = s.ctrl_a;
            tcr_pkg::IDX_CTRL_B: rd_byte = s.ctrl_b;
            tcr_pkg::IDX_FORCE: rd_byte = 8'h00;
            tcr_pkg::IDX_FLAGS: rd_byte = s.flags;
            tcr_pkg::IDX_CNT_LO: rd_byte = s.count[7:0];
            tcr_pkg::IDX_CAP_LO: rd_byte = s.capture[7:0];
            tcr_pkg::IDX_CMPA_LO: rd_byte = s.cmp_a[7:0];
            tcr_pkg::IDX_CMPB_LO: rd_byte = s.cmp_b[7:0];
            tcr_pkg::IDX_CNT_HI, tcr_pkg::IDX_CAP_HI, tcr_pkg::IDX_CMPA_HI,
            tcr_pkg::IDX_CMPB_HI: rd_byte = s.temp;
            default: map_hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        next_s = s;
        next_s.presc = s.presc + 1'b1;
        next_s.ext_prev = external_count_pin;

        // bus answer: one wait-free access phase after each setup cycle
        next_s.pready = setup_ph;
        next_s.pslverr = setup_ph && !(addr_ok && map_hit);
        if (setup_ph)
            next_s.prdata = (addr_ok && map_hit) ? {24'h000000, rd_byte} : 32'h00000000;

        // capture filter: needs four equal samples when enabled
        next_s.cap_hist = {s.cap_hist[tcr_pkg::NOISE_SAMPLES-2:0], cap_raw};
        next_s.cap_filt = next_filt;

        // counting sequence
        if (tick)
        begin
            next_s.block_match = 1'b0;
            case (kind)
                tcr_pkg::TCR_KIND_PHASE:
                begin
                    if (s.count_down)
                    begin
                        if (at_bottom)
                        begin
                            next_s.count_down = 1'b0;
                            next_s.count = s.count + 16'h0001;
                        end
                        else
                            next_s.count = s.count - 16'h0001;
                    end
                    else if (s.count >= top)
                    begin
                        next_s.count_down = 1'b1;
                        next_s.count = s.count - 16'h0001;
                    end
                    else
                        next_s.count = s.count + 16'h0001;
                end
                default:
                begin
                    next_s.count_down = 1'b0;
                    // top reached by the count itself, not by a forced match
                    if (at_top)
                        next_s.count = 16'h0000;
                    else
                        next_s.count = s.count + 16'h0001;
                end
            endcase
        end

        // waveform outputs on real matches, and at top in fast PWM
        case (kind)
            tcr_pkg::TCR_KIND_FAST:
            begin
                next_s.wave_a = act_pwm(s.wave_a, act_a, match_a, tick && at_top);
                next_s.wave_b = act_pwm(s.wave_b, act_b, match_b, tick && at_top);
            end
            tcr_pkg::TCR_KIND_PHASE:
            begin
                next_s.wave_a = act_pwm(s.wave_a, act_a, match_a && !s.count_down,
                                        match_a && s.count_down);
                next_s.wave_b = act_pwm(s.wave_b, act_b, match_b && !s.count_down,
                                        match_b && s.count_down);
            end
            default:
            begin
                if (match_a)
                    next_s.wave_a = act_match(s.wave_a, act_a);
                if (match_b)
                    next_s.wave_b = act_match(s.wave_b, act_b);
            end
        endcase

        // capture: disconnected while the capture pair is the top value
        if (!cap_is_top && cap_edge)
            next_s.capture = s.count;

        // register writes
        if (wr_done)
        begin
            case (idx)
                tcr_pkg::IDX_CTRL_A: next_s.ctrl_a = pwdata[7:0];
                tcr_pkg::IDX_CTRL_B: next_s.ctrl_b = pwdata[7:0];
                tcr_pkg::IDX_FORCE:
                begin
                    // force uses the action bits as they stand now; no flag, no clear
                    if (kind == tcr_pkg::TCR_KIND_NONPWM)
                    begin
                        if (pwdata[tcr_pkg::FC_A_BIT])
                            next_s.wave_a = act_match(s.wave_a, act_a);
                        if (pwdata[tcr_pkg::FC_B_BIT])
                            next_s.wave_b = act_match(s.wave_b, act_b);
                    end
                end
                tcr_pkg::IDX_CNT_LO:
                begin
                    next_s.count = {s.temp, pwdata[7:0]};
                    next_s.block_match = 1'b1;
                end
                tcr_pkg::IDX_CAP_LO: next_s.capture = {s.temp, pwdata[7:0]};
                tcr_pkg::IDX_CMPA_LO: next_s.cmp_a = {s.temp, pwdata[7:0]};
                tcr_pkg::IDX_CMPB_LO: next_s.cmp_b = {s.temp, pwdata[7:0]};
                tcr_pkg::IDX_CNT_HI, tcr_pkg::IDX_CAP_HI, tcr_pkg::IDX_CMPA_HI,
                tcr_pkg::IDX_CMPB_HI: next_s.temp = pwdata[7:0];
                default: next_s.temp = s.temp;
            endcase
        end

        // high byte frozen at the edge that samples the low byte, so both halves agree
        if (setup_ph && !pwrite && addr_ok)
        begin
            case (idx)
                tcr_pkg::IDX_CNT_LO: next_s.temp = s.count[15:8];
                tcr_pkg::IDX_CAP_LO: next_s.temp = s.capture[15:8];
                tcr_pkg::IDX_CMPA_LO: next_s.temp = s.cmp_a[15:8];
                tcr_pkg::IDX_CMPB_LO: next_s.temp = s.cmp_b[15:8];
                default: next_s.temp = next_s.temp;
            endcase
        end

        // sticky flags: write one clears, a same-cycle event wins
        if (wr_done && idx == tcr_pkg::IDX_FLAGS)
            next_s.flags = s.flags & ~pwdata[7:0];
        next_s.flags[7:6] = 2'b00;
        next_s.flags[4:3] = 2'b00;
        if (match_a)
            next_s.flags[tcr_pkg::FL_CMPA_BIT] = 1'b1;
        if (match_b)
            next_s.flags[tcr_pkg::FL_CMPB_BIT] = 1'b1;
        if (ovf)
            next_s.flags[tcr_pkg::FL_OVF_BIT] = 1'b1;
        if ((!cap_is_top && cap_edge) || (cap_is_top && tick && at_top))
            next_s.flags[tcr_pkg::FL_CAP_BIT] = 1'b1;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign wave_out_chan_a = s.wave_a;
    assign wave_out_chan_b = s.wave_b;

endmodule : tcr_timer16

// *** sim/tcr_timer16_assertions.sv ***
// checker: bus answer and read-back assertions on the timer ports
`timescale 1ns/1ps
module tcr_timer16_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wave_out_chan_a
);
    logic setup;
    logic mapped;
    assign setup = psel && !penable;
    assign mapped = paddr[1:0] == 2'h0 && paddr[11:2] >= tcr_pkg::IDX_CTRL_A
        && paddr[11:2] <= tcr_pkg::IDX_CMPB_HI;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************************************************************
    // assertions and covers
    // ****************************************************************
    ready_one_pulse_a: assert property (setup |=> pready ##1 !pready)
        else $error("answer is not one cycle after setup");
    no_stray_ready_a: assert property (!setup |=> !pready)
        else $error("answer without a setup cycle");
    unmapped_error_a: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_clean_a: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    force_reads_zero_a: assert property (setup && !pwrite
        && paddr[11:2] == tcr_pkg::IDX_FORCE |=> prdata == 32'h0)
        else $error("force strobes read back nonzero");
    upper_bytes_zero_a: assert property (prdata[31:8] == 24'h0)
        else $error("read data wider than a byte");
    read_data_holds_a: assert property (!setup |=> $stable(prdata))
        else $error("read data moved outside a setup");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    cover property (setup && pwrite && paddr[11:2] == tcr_pkg::IDX_FORCE);
    cover property (setup && !mapped);
    cover property ($changed(wave_out_chan_a));
endmodule : tcr_timer16_assertions

bind tcr_timer16 tcr_timer16_assertions chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wave_out_chan_a(wave_out_chan_a));

// *** sim/tcr_cpu_model.sv ***
// partner: byte-wide bus master standing in for the processor core
`timescale 1ns/1ps
module tcr_cpu_model (
    input wire logic pclk,
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    int timeouts = 0;
    initial
    begin
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] wd,
        output logic [7:0] rd);
        int n;
        @(posedge pclk);
        paddr <= {idx, 2'h0};
        pwrite <= wr;
        pwdata <= {24'h0, wd};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // answer taken at the rising edge where pready is seen high
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            timeouts++;
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show garbage, not their last value
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer
    task automatic wr8(input logic [9:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        xfer(idx, 1'b1, wd, d);
    endtask : wr8
    task automatic rd8(input logic [9:0] idx, output logic [7:0] rd);
        xfer(idx, 1'b0, 8'h00, rd);
    endtask : rd8
    // high byte first; rewriting a running count may skip a match
    task automatic wr16(input logic [9:0] lo, input logic [15:0] v);
        wr8(lo + 10'h001, v[15:8]);
        wr8(lo, v[7:0]);
    endtask : wr16
    // low byte first so the high byte comes from the same instant
    task automatic rd16(input logic [9:0] lo, output logic [15:0] v);
        rd8(lo, v[7:0]);
        rd8(lo + 10'h001, v[15:8]);
    endtask : rd16
endmodule : tcr_cpu_model

// *** sim/testbench.sv ***
// testbench: registers, clock select, capture and forced compare of the timer
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic cap_pin = 1'b0;
    logic ana_in = 1'b0;
    logic ext_pin = 1'b0;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, wave_a, wave_b;
    logic [31:0] pwdata, prdata;
    logic [15:0] v0, v1;
    logic [7:0] b;
    int fails = 0;
    int comparisons = 0;
    int dv[6] = '{0, 1, 8, 64, 256, 1024};
    initial forever #2.5 pclk = ~pclk;
    tcr_timer16 uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_input_pin(cap_pin),
        .analog_cmp_in(ana_in), .external_count_pin(ext_pin),
        .wave_out_chan_a(wave_a), .wave_out_chan_b(wave_b));
    tcr_cpu_model cpu (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready));
    // a bus answer missing for 50 cycles ends the run at the next edge
    always @(posedge pclk)
        if (cpu.timeouts != 0)
            finish_test();
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        fails += cpu.timeouts;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic force_chk(input logic [7:0] act, input logic [7:0] f, input logic [1:0] exp);
        cpu.wr8(tcr_pkg::IDX_CTRL_A, act);
        cpu.wr8(tcr_pkg::IDX_FORCE, f);
        repeat (3) @(posedge pclk);
        chk({14'h0, wave_a, wave_b}, {14'h0, exp});
    endtask : force_chk
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            cpu.rd16(tcr_pkg::IDX_CNT_LO + 10'(2 * i), v0);
            chk(v0, 16'h0000);
        end
        for (int i = 1; i < 4; i++)
        begin
            cpu.wr16(tcr_pkg::IDX_CNT_LO + 10'(2 * i), 16'hA5C0 + 16'(i));
            cpu.rd16(tcr_pkg::IDX_CNT_LO + 10'(2 * i), v0);
            chk(v0, 16'hA5C0 + 16'(i));
        end
        cpu.rd8(10'h0A0, b);
        chk({8'h0, b}, 16'h0000);
        // one latch for all pairs: a high byte meant for A lands in B
        cpu.wr8(tcr_pkg::IDX_CMPA_HI, 8'h5A);
        cpu.wr8(tcr_pkg::IDX_CMPB_LO, 8'h3C);
        cpu.rd16(tcr_pkg::IDX_CMPB_LO, v0);
        chk(v0, 16'h5A3C);
        cpu.rd8(tcr_pkg::IDX_CAP_LO, b);
        cpu.rd8(tcr_pkg::IDX_CMPA_HI, b);
        chk({8'h0, b}, 16'h00A5);
        // counter stopped, so only strobes move the outputs
        cpu.wr8(tcr_pkg::IDX_FLAGS, 8'hFF);
        force_chk(8'h50, 8'h80, 2'b10);
        force_chk(8'h50, 8'h40, 2'b11);
        force_chk(8'h90, 8'h80, 2'b01);
        force_chk(8'hD0, 8'h80, 2'b11);
        cpu.rd8(tcr_pkg::IDX_FORCE, b);
        chk({8'h0, b}, 16'h0000);
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h08);
        cpu.wr16(tcr_pkg::IDX_CNT_LO, 16'h0005);
        force_chk(8'h90, 8'h80, 2'b01);
        cpu.rd16(tcr_pkg::IDX_CNT_LO, v0);
        chk(v0, 16'h0005);
        cpu.rd8(tcr_pkg::IDX_FLAGS, b);
        chk({8'h0, b & 8'h06}, 16'h0000);
        force_chk(8'hD1, 8'h80, 2'b01);
        cpu.wr8(tcr_pkg::IDX_CTRL_A, 8'h00);
        // capture from the pin, from the comparator, then disconnected as top
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h40);
        cpu.wr16(tcr_pkg::IDX_CNT_LO, 16'hABCD);
        cap_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        cpu.rd16(tcr_pkg::IDX_CAP_LO, v0);
        chk(v0, 16'hABCD);
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h60);
        cpu.wr16(tcr_pkg::IDX_CNT_LO, 16'h1357);
        ana_in <= 1'b1;
        repeat (8) @(posedge pclk);
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h58);
        cpu.wr16(tcr_pkg::IDX_CNT_LO, 16'h2468);
        cap_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        cap_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        cpu.rd16(tcr_pkg::IDX_CAP_LO, v0);
        chk(v0, 16'h1357);
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h40);
        // ticks over a window of whole prescaler periods
        for (int i = 0; i < 6; i++)
        begin
            cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'(i));
            cpu.rd16(tcr_pkg::IDX_CNT_LO, v0);
            repeat (dv[i] < 2 ? (1 - dv[i]) * 10 : 4 * dv[i] - 6) @(posedge pclk);
            cpu.rd16(tcr_pkg::IDX_CNT_LO, v1);
            chk(v1 - v0, dv[i] == 0 ? 16'h0 : dv[i] == 1 ? 16'h6 : 16'h4);
        end
        for (int c = 6; c < 8; c++)
        begin
            cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'(c));
            cpu.rd16(tcr_pkg::IDX_CNT_LO, v0);
            repeat (6)
            begin
                ext_pin <= ~ext_pin;
                repeat (4) @(posedge pclk);
            end
            cpu.rd16(tcr_pkg::IDX_CNT_LO, v1);
            chk(v1 - v0, 16'h3);
        end
        // rewrite onto compare A: that match is lost, B still fires
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h00);
        cpu.wr16(tcr_pkg::IDX_CMPA_LO, 16'h0010);
        cpu.wr16(tcr_pkg::IDX_CMPB_LO, 16'h0014);
        cpu.wr16(tcr_pkg::IDX_CNT_LO, 16'h8000);
        cpu.wr8(tcr_pkg::IDX_FLAGS, 8'hFF);
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h01);
        cpu.wr16(tcr_pkg::IDX_CNT_LO, 16'h0010);
        repeat (10) @(posedge pclk);
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h00);
        cpu.rd8(tcr_pkg::IDX_FLAGS, b);
        chk({8'h0, b & 8'h06}, 16'h0004);
        cpu.wr8(tcr_pkg::IDX_FLAGS, 8'hFF);
        cpu.wr16(tcr_pkg::IDX_CNT_LO, 16'h000E);
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h01);
        repeat (10) @(posedge pclk);
        cpu.wr8(tcr_pkg::IDX_CTRL_B, 8'h00);
        cpu.rd8(tcr_pkg::IDX_FLAGS, b);
        chk({8'h0, b & 8'h06}, 16'h0006);
        finish_test();
    end
endmodule : testbench
